// File: include/lbm_pkg.sv
package lbm_pkg;

   // Observation cycle length and the clock rate it is counted at.
   localparam int CYCLE_MS = 128;
   localparam int CLK_HZ = 10_000_000;
   // Cycles per observation window; the product stays below two to the thirty-first.
   localparam int CYCLE_TICKS = CYCLE_MS * (CLK_HZ / 1000);
   localparam int TICK_W = 21;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_UPPER_THR = 8'h58;
   localparam logic [7:0] IDX_LOWER_THR = 8'h59;
   localparam logic [7:0] IDX_BUCKET_SIZE = 8'h5a;
   localparam logic [7:0] IDX_LEAK_RATE = 8'h5b;
   localparam logic [7:0] IDX_STATUS = 8'h60;

   // Reset values.
   localparam logic [7:0] RST_UPPER_THR = 8'h06;
   localparam logic [7:0] RST_LOWER_THR = 8'h04;
   localparam logic [7:0] RST_BUCKET_SIZE = 8'h08;
   localparam logic [1:0] RST_LEAK_RATE = 2'h1;

   // Field layout: leak rate in bits 1:0, status count in 7:0 and alarm in bit 8.
   localparam int LEAK_RATE_W = 2;
   localparam int STAT_ALARM_BIT = 8;
   localparam int PADDR_W = 12;

   // Smallest legal bucket size; a written zero is treated as this.
   localparam logic [7:0] MIN_BUCKET_SIZE = 8'h01;

   // Alarm state, one bit so the two states differ in one bit.
   typedef enum logic {
      AL_CLEAR = 1'b0,
      AL_RAISED = 1'b1
   } lbm_alarm_e;

endpackage

// File: logic/lbm_cycle_timer.sv
`timescale 1ns/1ps
module lbm_cycle_timer
   import lbm_pkg::*;
#(
   parameter int TICKS = CYCLE_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic cycle_end
);

   logic [TICK_W-1:0] tick_count;

   // Free-running window counter; wraps at the end of every observation cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count <= '0;
      end else if (tick_count == TICK_W'(TICKS - 1)) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + TICK_W'(1);
      end
   end

   // Registered end-of-window pulse, one clock wide.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_end <= 1'b0;
      end else begin
         cycle_end <= (tick_count == TICK_W'(TICKS - 1));
      end
   end

endmodule

// File: logic/lbm_monitor.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Activity is judged over back-to-back fixed observation windows of 128 ms and the count moves only at their end or on a lowered bucket size.
// - Each window in which the input was failed or erratic adds exactly one to the count.
// - A whole decay period without any faulty window takes exactly one from the count at its end.
// - Leak rate codes 00, 01, 10 and 11 give decay periods of 1, 2, 4 and 8 windows.
// - The count never exceeds the bucket size, 1 to 255, and faulty windows at the top leave it unchanged.
// - The inactivity alarm rises when the count reaches the upper threshold.
// - A raised alarm clears when the count falls to the lower threshold.
module lbm_monitor
   import lbm_pkg::*;
#(
   parameter int TICKS = CYCLE_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_fault,
   output logic [7:0] bucket_count,
   output logic inactivity_alarm
);

   // Byte address of a register index.
   function automatic logic [PADDR_W-1:0] addr_of(input logic [7:0] idx);
      addr_of = {2'b00, idx, 2'b00};
   endfunction

   // Number of windows in one decay period for a leak rate code.
   function automatic logic [3:0] period_of(input logic [LEAK_RATE_W-1:0] rate);
      period_of = 4'h1 << rate;
   endfunction

   // Bucket size in force; a written zero acts as the smallest legal size.
   function automatic logic [7:0] size_of(input logic [7:0] sz);
      size_of = (sz == 8'h00) ? MIN_BUCKET_SIZE : sz;
   endfunction

   logic [7:0] upper_thr;
   logic [7:0] lower_thr;
   logic [7:0] bucket_max_size_set2;
   logic [LEAK_RATE_W-1:0] bucket_leak_rate_set2;
   logic cycle_end;
   logic fault_seen;
   logic cyc_faulty;
   logic [2:0] quiet_cycles;
   logic decay_hit;
   logic [7:0] eff_size;
   logic [7:0] next_count;
   lbm_alarm_e alarm_state;
   lbm_alarm_e next_alarm;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [31:0] rd_mux;

   // Window timer; its pulse paces every change of the count except the pull-down to a lowered bucket size.
   lbm_cycle_timer #(
      .TICKS(TICKS)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .cycle_end(cycle_end)
   );

   // Bus decode. The slave answers in the first access cycle, so pready is held high.
   assign mapped = (paddr == addr_of(IDX_UPPER_THR)) || (paddr == addr_of(IDX_LOWER_THR)) ||
                   (paddr == addr_of(IDX_BUCKET_SIZE)) || (paddr == addr_of(IDX_LEAK_RATE)) ||
                   (paddr == addr_of(IDX_STATUS));
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // Configuration registers; writes land at the access edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_thr <= RST_UPPER_THR;
         lower_thr <= RST_LOWER_THR;
         bucket_max_size_set2 <= RST_BUCKET_SIZE;
         bucket_leak_rate_set2 <= RST_LEAK_RATE;
      end else if (wr_en) begin
         if (paddr == addr_of(IDX_UPPER_THR)) begin
            upper_thr <= pwdata[7:0];
         end
         if (paddr == addr_of(IDX_LOWER_THR)) begin
            lower_thr <= pwdata[7:0];
         end
         if (paddr == addr_of(IDX_BUCKET_SIZE)) begin
            bucket_max_size_set2 <= pwdata[7:0];
         end
         if (paddr == addr_of(IDX_LEAK_RATE)) begin
            bucket_leak_rate_set2 <= pwdata[LEAK_RATE_W-1:0];
         end
      end
   end

   // Read multiplexer; unused upper bits read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == addr_of(IDX_UPPER_THR)) begin
         rd_mux = {24'h00_0000, upper_thr};
      end else if (paddr == addr_of(IDX_LOWER_THR)) begin
         rd_mux = {24'h00_0000, lower_thr};
      end else if (paddr == addr_of(IDX_BUCKET_SIZE)) begin
         rd_mux = {24'h00_0000, bucket_max_size_set2};
      end else if (paddr == addr_of(IDX_LEAK_RATE)) begin
         rd_mux = {30'h0000_0000, bucket_leak_rate_set2};
      end else if (paddr == addr_of(IDX_STATUS)) begin
         rd_mux = {23'h00_0000, inactivity_alarm, bucket_count};
      end
   end

   // Read data is captured in the setup cycle so it comes from a flip-flop in the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // A fault anywhere in the window marks it; a fault on the closing edge still counts for this window.
   assign cyc_faulty = fault_seen || ref_fault;

   // Window fault memory; it may clear on the closing edge because that edge is already folded into cyc_faulty.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_seen <= 1'b0;
      end else if (cycle_end) begin
         fault_seen <= 1'b0;
      end else if (ref_fault) begin
         fault_seen <= 1'b1;
      end
   end

   // Quiet windows since the last decrement or fault; a faulty window restarts the period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_cycles <= 3'h0;
      end else if (cycle_end) begin
         if (cyc_faulty || decay_hit) begin
            quiet_cycles <= 3'h0;
         end else begin
            quiet_cycles <= quiet_cycles + 3'h1;
         end
      end
   end

   // The period ends on the window that completes the programmed number of clean windows.
   // Reprogramming to a shorter period ends it at the first clean window that brings the clean windows counted to the new length or beyond.
   assign decay_hit = cycle_end && !cyc_faulty &&
                      ({1'b0, quiet_cycles} + 4'h1 >= period_of(bucket_leak_rate_set2));
   assign eff_size = size_of(bucket_max_size_set2);

   // Next count. Lowering the size below the count pulls the count down at once.
   always_comb begin
      next_count = bucket_count;
      if (cycle_end && cyc_faulty) begin
         if (bucket_count < eff_size) begin
            next_count = bucket_count + 8'h01;
         end
      end else if (decay_hit && bucket_count != 8'h00) begin
         next_count = bucket_count - 8'h01;
      end
      if (next_count > eff_size) begin
         next_count = eff_size;
      end
   end

   // Count register; it only ever moves by one, or down to a smaller bucket size.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bucket_count <= 8'h00;
      end else begin
         bucket_count <= next_count;
      end
   end

   // Alarm with hysteresis between the two thresholds.
   always_comb begin
      case (alarm_state)
         AL_CLEAR: begin
            next_alarm = (bucket_count >= upper_thr) ? AL_RAISED : AL_CLEAR;
         end
         AL_RAISED: begin
            next_alarm = (bucket_count <= lower_thr) ? AL_CLEAR : AL_RAISED;
         end
         default: begin
            next_alarm = AL_CLEAR;
         end
      endcase
   end

   // Alarm register; it lags the count by one clock, which keeps the pin free of glitches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_state <= AL_CLEAR;
      end else begin
         alarm_state <= next_alarm;
      end
   end

   // The alarm pin is a plain decode of the one-bit state register.
   assign inactivity_alarm = (alarm_state == AL_RAISED);

   // Checks on the count, the decay pacing and the alarm.
   // The window checks need TICKS of three or more, which every useful setting far exceeds.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_window_spacing: assert property (
      cycle_end ##1 (bucket_count <= eff_size) |->
      !cycle_end ##1 (!cycle_end && (bucket_count == $past(bucket_count)))
   ) else $error("count moved between windows");

   chk_count_still: assert property (
      !cycle_end && (bucket_count <= eff_size) && $stable(eff_size) |=> bucket_count == $past(bucket_count)
   ) else $error("count changed outside a window end");

   chk_fault_adds_one: assert property (
      cycle_end && cyc_faulty && (bucket_count < eff_size) && $stable(eff_size)
      |=> bucket_count == $past(bucket_count) + 8'h01
   ) else $error("faulty window did not add one");

   chk_decay_takes_one: assert property (
      decay_hit && (bucket_count != 8'h00) && (bucket_count <= eff_size)
      |=> bucket_count == $past(bucket_count) - 8'h01
   ) else $error("decay period did not take one");

   // The period table is spelled out here on purpose, apart from the decoding function.
   chk_decay_period: assert property (
      decay_hit && $stable(bucket_leak_rate_set2) |->
      ({1'b0, quiet_cycles} + 4'h1) == ((bucket_leak_rate_set2 == 2'h0) ? 4'h1 :
                                        (bucket_leak_rate_set2 == 2'h1) ? 4'h2 :
                                        (bucket_leak_rate_set2 == 2'h2) ? 4'h4 : 4'h8)
   ) else $error("decay period length wrong");

   chk_size_ceiling: assert property (
      ##1 bucket_count <= $past(eff_size)
   ) else $error("count above bucket size");

   chk_full_holds: assert property (
      cycle_end && cyc_faulty && (bucket_count == eff_size) && $stable(eff_size) |=> bucket_count == $past(bucket_count)
   ) else $error("full bucket changed on a fault");

   chk_alarm_rise: assert property (
      !inactivity_alarm && (bucket_count >= upper_thr) |=> inactivity_alarm
   ) else $error("alarm not raised at upper threshold");

   chk_alarm_clear: assert property (
      inactivity_alarm && (bucket_count <= lower_thr) |=> !inactivity_alarm
   ) else $error("alarm not cleared at lower threshold");

   chk_floor_zero: assert property (
      decay_hit && (bucket_count == 8'h00) |=> bucket_count == 8'h00
   ) else $error("count left zero on decay");

   chk_fault_kept: assert property (
      ref_fault && !cycle_end |=> fault_seen
   ) else $error("fault inside a window was not remembered");

   chk_clean_no_add: assert property (
      cycle_end && !cyc_faulty |=> bucket_count <= $past(bucket_count)
   ) else $error("clean window raised the count");

   chk_fault_restarts: assert property (
      cycle_end && cyc_faulty |=> quiet_cycles == 3'h0
   ) else $error("faulty window did not restart the decay period");

   chk_alarm_wait: assert property (
      !inactivity_alarm && (bucket_count < upper_thr) |=> !inactivity_alarm
   ) else $error("alarm raised below upper threshold");

   chk_alarm_hold: assert property (
      inactivity_alarm && (bucket_count > lower_thr) |=> inactivity_alarm
   ) else $error("alarm cleared above lower threshold");

   // Register writes land at the access edge, cut to the field width; the bench reads back only some of them.
   chk_size_write: assert property (
      wr_en && (paddr == addr_of(IDX_BUCKET_SIZE)) |=> {24'h00_0000, bucket_max_size_set2} == ($past(pwdata) & 32'h0000_00ff)
   ) else $error("bucket size write did not land");

   chk_leak_write: assert property (
      wr_en && (paddr == addr_of(IDX_LEAK_RATE)) |=> {30'h0000_0000, bucket_leak_rate_set2} == ($past(pwdata) & 32'h0000_0003)
   ) else $error("leak rate write did not land");

   chk_upper_write: assert property (
      wr_en && (paddr == addr_of(IDX_UPPER_THR)) |=> {24'h00_0000, upper_thr} == ($past(pwdata) & 32'h0000_00ff)
   ) else $error("upper threshold write did not land");

   // Cover points for the main scenarios.
   cov_fill_to_top: cover property (cycle_end && cyc_faulty && bucket_count == eff_size);
   cov_size_floor: cover property (cycle_end && cyc_faulty && bucket_max_size_set2 == 8'h00 && bucket_count == 8'h01);
   cov_decay_slow: cover property (decay_hit && bucket_leak_rate_set2 == 2'h3);
   cov_alarm_raise: cover property (!inactivity_alarm ##1 inactivity_alarm);
   cov_alarm_drop: cover property (inactivity_alarm ##1 !inactivity_alarm);

endmodule

// File: tb/lbm_testbench.sv
`timescale 1ns/1ps
module testbench;
   import lbm_pkg::*;
   // A short window keeps the run small; every expectation is counted in windows, not clocks.
   localparam int T = 16;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic ref_fault = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] bucket_count;
   logic inactivity_alarm;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 32'h9d8ebbac;
   logic [32:0] exp_q[$];
   logic [32:0] mon_exp;
   // Bench copy of the bucket: count, clean windows in a row, decay period and alarm.
   int cnt = 0;
   int quiet = 0;
   int per = 2;
   logic al = 1'b0;
   int sz = 3;
   int k = 0;

   lbm_monitor #(.TICKS(T)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_fault(ref_fault), .bucket_count(bucket_count), .inactivity_alarm(inactivity_alarm)
   );

   // The clock toggles every half period.
   always #50 pclk = ~pclk;

   // Clocks since reset release; windows are located from this so faults land mid-window.
   always @(posedge pclk) begin
      if (!presetn) cyc <= 0;
      else cyc <= cyc + 1;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      total_checks++;
      if (seen !== want) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic summarize();
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One transfer; the slave holds pready high, yet the wait for it is bounded, not assumed.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] want);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      if (!wr) exp_q.push_back(want);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [32:0] st();
      return {1'b0, 23'h0, al, 8'(cnt)};
   endfunction

   // Advance the bench copy by one window; size is sz, upper threshold 2, lower 1.
   task automatic window(input logic f);
      if (f) begin
         if (cnt < sz) cnt++;
         quiet = 0;
      end else begin
         quiet++;
         if (quiet >= per) begin
            if (cnt > 0) cnt--;
            quiet = 0;
         end
      end
      if (!al && cnt >= 2) al = 1'b1;
      else if (al && cnt <= 1) al = 1'b0;
   endtask

   // One window: a one-clock fault pulse mid-window when f is set, a status read, then the bench copy moves on.
   task automatic step(input logic f);
      int n;
      n = 0;
      while (cyc < k * T + 9 && n < 4 * T) begin
         @(posedge pclk);
         n++;
      end
      if (cyc < k * T + 9) begin
         errors++;
         summarize();
      end
      ref_fault <= f;
      @(posedge pclk);
      ref_fault <= 1'b0;
      apb(1'b0, IDX_STATUS, 32'h0, st());
      window(f);
      k++;
   endtask

   // Each completed read takes the oldest note; status reads also compare the output pins.
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready === 1'b1 && !pwrite) begin
         mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
         check({pslverr, prdata}, mon_exp);
         if (paddr == {2'b00, IDX_STATUS, 2'b00}) check({24'h0, inactivity_alarm, bucket_count}, mon_exp);
      end
   end

   // Reset values, register access, four random fault phases, one per decay code, then a zero size.
   initial begin
      int rnd;
      logic f;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, IDX_BUCKET_SIZE, 32'h0, {25'h0, RST_BUCKET_SIZE});
      apb(1'b0, IDX_LEAK_RATE, 32'h0, {31'h0, RST_LEAK_RATE});
      apb(1'b0, IDX_UPPER_THR, 32'h0, {25'h0, RST_UPPER_THR});
      apb(1'b0, IDX_LOWER_THR, 32'h0, {25'h0, RST_LOWER_THR});
      apb(1'b0, 8'h5c, 32'h0, {1'b1, 32'h0});
      apb(1'b1, IDX_BUCKET_SIZE, 32'h3, 33'h0);
      apb(1'b1, IDX_UPPER_THR, 32'h2, 33'h0);
      apb(1'b1, IDX_LOWER_THR, 32'h1, 33'h0);
      apb(1'b1, IDX_STATUS, 32'h1ff, 33'h0);
      apb(1'b0, IDX_BUCKET_SIZE, 32'h0, 33'h3);
      apb(1'b0, IDX_STATUS, 32'h0, st());
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, IDX_LEAK_RATE, 32'hfffffffc | r, 33'h0);
         apb(1'b0, IDX_LEAK_RATE, 32'h0, 33'(r));
         per = 1 << r;
         k = cyc / T + 1;
         // Ten mostly faulty windows, then enough clean ones to drain to zero and idle there.
         for (int w = 0; w < 12 + 3 * per; w++) begin
            rnd = $random(seed);
            f = (w < 10) ? (rnd[1:0] != 2'b00) : 1'b0;
            step(f);
         end
      end
      // A written size of zero acts as one, so two faulty windows leave the count at one.
      apb(1'b1, IDX_BUCKET_SIZE, 32'h0, 33'h0);
      apb(1'b0, IDX_BUCKET_SIZE, 32'h0, 33'h0);
      sz = 1;
      k = cyc / T + 1;
      step(1'b1);
      step(1'b1);
      step(1'b0);
      summarize();
   end
endmodule
